// ### common/cpid_defines.svh
// offsets, field positions, reset values and timing counts of the coupler process image block
// assumes a 40 MHz clk; included by bare name
`ifndef CPID_DEFINES_SVH
`define CPID_DEFINES_SVH
`define CPID_CLK_MHZ          40
`define CPID_BLINK_MS         250
`define CPID_BLINK_CYCLES     (`CPID_BLINK_MS * 1000 * `CPID_CLK_MHZ)
`define CPID_BOOT_US          100
`define CPID_BOOT_CYCLES      (`CPID_BOOT_US * `CPID_CLK_MHZ)
`define CPID_DELAY_UNIT_MS    100
`define CPID_DELAY_UNIT_CYC   (`CPID_DELAY_UNIT_MS * 1000 * `CPID_CLK_MHZ)
`define CPID_DIAG_DEPTH       8
`define CPID_OUT_USED_MSB     3
`define CPID_PRM_EN_BUSDIAG   0
`define CPID_PRM_EN_IODIAG    1
`define CPID_PRM_EN_RETURN    2
`define CPID_PRM_AUTO_START   3
`define CPID_PRM_DELAY_LSB    8
`define CPID_PRM_DELAY_MSB    15
`define CPID_PRM_RESET        16'h0000
`define CPID_STATUS_FAULT_BIT 15
`define CPID_FSTAT_BUSY_BIT   0
`define CPID_FSTAT_ERRSTOP    1
`endif

// ### common/cpid_pkg.sv
// types shared by the coupler process image block
// assumes cpid_defines.svh for numeric constants
package cpid_pkg;
   typedef struct packed {
      logic [15:0] word1;
      logic [15:0] word2;
      logic [15:0] word3;
      logic [15:0] word4;
   } cpid_mgmt_type;

   typedef struct packed {
      logic [7:0] location;
      logic [7:0] err_type;
   } cpid_diag_type;

   typedef struct packed {
      logic       valid;
      logic       incoming;
      cpid_diag_type entry;
   } cpid_alarm_type;

   typedef enum logic [1:0] {
      CPID_BOOT    = 2'b00,
      CPID_RUN     = 2'b01,
      CPID_ERRSTOP = 2'b10,
      CPID_RESTART = 2'b11
   } cpid_state_type;
endpackage

// ### verif/cpid_coupler_bench.sv
// self-checking bench of the coupler process image block
// assumes cpid_plc_model on the controller side; inputs change on falling edges
module cpid_coupler_bench
   import cpid_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic           clk, rst_n, reset_button_n, name_assign, bus_error, device_error;
   logic           diag_add, diag_remove, diag_is_io, module_return, func_done;
   logic           link_up, conn_active, conn_start, link_fault_lamp, system_fault_lamp;
   logic           named, booted;
   logic [15:0]    slot0_param, ext_status, func_start, func_param;
   logic [7:0]     slot2_out, local_input_pin, slot3_in;
   logic [3:0]     local_output;
   cpid_diag_type  diag_entry;
   cpid_mgmt_type  slot1_out, slot1_in;
   cpid_alarm_type alarm;
   int             n_mismatch, num_checks;

   cpid_plc_model u_cpid_plc_model (.clk(clk), .link_up(link_up), .conn_active(conn_active),
      .conn_start(conn_start), .slot0_param(slot0_param));

   cpid_coupler u_cpid_coupler (.clk(clk), .rst_n(rst_n), .reset_button_n(reset_button_n),
      .link_up(link_up), .conn_active(conn_active), .conn_start(conn_start),
      .slot0_param(slot0_param), .name_assign(name_assign), .bus_error(bus_error),
      .device_error(device_error), .diag_add(diag_add), .diag_remove(diag_remove),
      .diag_is_io(diag_is_io), .module_return(module_return), .diag_entry(diag_entry),
      .slot1_out(slot1_out), .slot2_out(slot2_out), .local_input_pin(local_input_pin),
      .ext_status(ext_status), .func_done(func_done), .slot1_in(slot1_in), .slot3_in(slot3_in),
      .local_output(local_output), .func_start(func_start), .func_param(func_param),
      .link_fault_lamp(link_fault_lamp), .system_fault_lamp(system_fault_lamp),
      .alarm(alarm), .named(named), .booted(booted));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task report_and_stop;
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task wait_boot;
      int i;
      i = 0;
      while (booted !== 1'b1 && i < 5000)
      begin
         @(negedge clk);
         i++;
      end
      if (i == 5000)
      begin
         n_mismatch++;
         report_and_stop;
      end
   endtask

   // alarm valid stands one cycle, so every falling edge is looked at
   task wait_alarm(output logic got, output cpid_alarm_type a);
      got = 1'b0;
      a   = '0;
      repeat (8)
      begin
         @(negedge clk);
         if (alarm.valid === 1'b1 && !got)
         begin
            got = 1'b1;
            a   = alarm;
         end
      end
   endtask

   task pulse_diag(input logic add, input logic [15:0] ent);
      diag_entry  = ent;
      diag_add    = add;
      diag_remove = ~add;
      @(negedge clk);
      diag_add    = 1'b0;
      diag_remove = 1'b0;
      diag_entry  = '0;
   endtask

   task s_reset;
      chk(link_fault_lamp, 1'b1);
      chk(local_output, 4'h0);
      chk(alarm.valid, 1'b0);
      rst_n = 1'b1;
      wait_boot();
      cyc(2);
      chk(link_fault_lamp, 1'b1);
      chk(named, 1'b0);
      name_assign = 1'b1;
      cyc(1);
      name_assign = 1'b0;
      cyc(2);
      chk(named, 1'b1);
   endtask

   task s_io;
      logic [7:0] v [4];
      v = '{8'hA5, 8'h5A, 8'hF0, 8'h0F};
      foreach (v[k])
      begin
         slot2_out       = v[k];
         local_input_pin = v[k] ^ 8'h3C;
         cyc(4);
         chk(local_output, v[k][3:0]);
         chk(slot3_in, v[k] ^ 8'h3C);
      end
   endtask

   task s_mgmt;
      slot1_out  = {16'h1234, 16'h5678, 16'hFFFF, 16'hAAAA};
      ext_status = 16'h7ABC;
      cyc(3);
      chk(func_start, 16'h1234);
      chk(func_param, 16'h5678);
      chk(slot1_in.word1, 16'h7ABC);
      chk(slot1_in.word3, 16'h0000);
      chk(slot1_in.word4, 16'h0001);
      func_done = 1'b1;
      cyc(1);
      chk(slot1_in.word4, 16'h0000);
      func_done = 1'b0;
   endtask

   task s_diag;
      logic           got;
      cpid_alarm_type a;
      u_cpid_plc_model.set_link(1'b1);
      u_cpid_plc_model.open_conn(16'h0007);
      cyc(3);
      chk(link_fault_lamp, 1'b0);
      pulse_diag(1'b1, 16'h2107);
      wait_alarm(got, a);
      chk(got, 1'b1);
      chk({a.incoming, a.entry}, 17'h12107);
      chk(system_fault_lamp, 1'b1);
      chk(slot1_in.word2, 16'h2107);
      chk(slot1_in.word3, 16'h0001);
      chk(slot1_in.word1[15], 1'b1);
      pulse_diag(1'b0, 16'h2107);
      wait_alarm(got, a);
      chk({got, a.incoming, a.entry}, 18'h22107);
      chk(system_fault_lamp, 1'b0);
      module_return = 1'b1;
      cyc(1);
      module_return = 1'b0;
      chk({alarm.valid, alarm.incoming}, 2'b10);
   endtask

   task s_disabled;
      logic           got;
      cpid_alarm_type a;
      u_cpid_plc_model.open_conn(16'h0001);
      u_cpid_plc_model.poke_param(16'h0003);
      diag_is_io = 1'b1;
      pulse_diag(1'b1, 16'h4405);
      wait_alarm(got, a);
      diag_is_io = 1'b0;
      chk(got, 1'b0);
      chk(system_fault_lamp, 1'b1);
   endtask

   task s_error;
      for (int k = 0; k < 2; k++)
      begin
         slot2_out = 8'hFF;
         cyc(2);
         chk(local_output, 4'hF);
         bus_error    = (k == 0);
         device_error = (k == 1);
         cyc(3);
         chk(local_output, 4'h0);
         bus_error    = 1'b0;
         device_error = 1'b0;
         cyc(3);
         chk(local_output, 4'h0);
         chk(func_start, 16'h0000);
         chk(slot1_in.word4, 16'h0002);
         local_input_pin = 8'h81;
         cyc(4);
         reset_button_n  = 1'b0;
         cyc(4);
         reset_button_n  = 1'b1;
         local_input_pin = 8'h7E;
         cyc(6);
         chk(booted, 1'b0);
         chk(local_output, 4'h0);
         chk(slot3_in, 8'h81);
         chk(system_fault_lamp, 1'b0);
         wait_boot();
         cyc(2);
         chk(local_output, 4'hF);
      end
   endtask

   initial
   begin
      n_mismatch      = 0;
      num_checks      = 0;
      rst_n           = 1'b0;
      reset_button_n  = 1'b1;
      name_assign     = 1'b0;
      bus_error       = 1'b0;
      device_error    = 1'b0;
      diag_add        = 1'b0;
      diag_remove     = 1'b0;
      diag_is_io      = 1'b0;
      module_return   = 1'b0;
      func_done       = 1'b0;
      diag_entry      = '0;
      slot1_out       = '0;
      slot2_out       = 8'h00;
      local_input_pin = 8'h00;
      ext_status      = 16'h0000;
      cyc(5);
      s_reset();
      s_io();
      s_mgmt();
      s_diag();
      s_disabled();
      s_error();
      report_and_stop();
   end
endmodule

// ### verif/cpid_plc_model.sv
// controller model: link, connection startup and slot 0 parameters
// assumes the bench calls its tasks; drives on the falling clock edge
module cpid_plc_model
(
   input  wire logic        clk,         // 40 MHz clock
   output logic             link_up,     // physical link present
   output logic             conn_active, // connection held
   output logic             conn_start,  // startup pulse
   output logic [15:0]      slot0_param  // slot 0 parameters
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      link_up     = 1'b0;
      conn_active = 1'b0;
      conn_start  = 1'b0;
      slot0_param = 16'h0000;
   end

   task set_link(input logic up);
      @(negedge clk);
      link_up = up;
   endtask

   // enables go out during connection startup, together with the conn_start pulse
   task open_conn(input logic [15:0] prm);
      @(negedge clk);
      conn_active = 1'b0;
      slot0_param = prm;
      conn_start  = 1'b1;
      @(negedge clk);
      conn_start  = 1'b0;
      conn_active = 1'b1;
   endtask

   // parameter change outside startup
   task poke_param(input logic [15:0] prm);
      @(negedge clk);
      slot0_param = prm;
   endtask
endmodule

// ### verilog/cpid_coupler.sv
// process image and diagnostics core of a field-bus coupler
// assumes cyclic words and events come from same-clock logic; pins and button are asynchronous
//
// Contract
// - three cyclic slots: mgmt, output byte, input byte
// - output bits 0..3 drive outputs, 4..7 ignored
// - input n lands on byte bit n-1
// - mgmt words: status, params in; start, param out
// - reset button restarts, clears outputs, keeps inputs
// - boot ends with link lamp lit or flashing; code turns it off right after boot when link and connection are held
// - store each diagnostic with location and type; code holds at most 8 entries, further adds are dropped
// - stored entry raises incoming alarm
// - alarms sent only when enabled at startup
// - cleared entry raises outgoing alarm
// - system lamp lit iff entries stored
// - bus or device error zeroes all outputs
// - slot 0 parameters: alarm enables, auto restart
// - no station name or address on delivery
// - link lamp: on no link, flash, off connected
`include "cpid_defines.svh"
module cpid_coupler
   import cpid_pkg::*;
(
   input  wire logic           clk,            // 40 MHz clock
   input  wire logic           rst_n,          // async reset, low
   input  wire logic           reset_button_n, // front button pin, low pressed
   input  wire logic           link_up,        // physical link present
   input  wire logic           conn_active,    // controller connection held
   input  wire logic           conn_start,     // pulse: connection being set up
   input  wire logic [15:0]    slot0_param,    // slot 0 parameter record
   input  wire logic           name_assign,    // pulse: name and address assigned
   input  wire logic           bus_error,      // extension bus error level
   input  wire logic           device_error,   // internal device error level
   input  wire logic           diag_add,       // pulse: new diagnostic
   input  wire logic           diag_remove,    // pulse: diagnostic gone
   input  wire logic           diag_is_io,     // diagnostic is I/O class
   input  wire logic           module_return,  // pulse: local module returned
   input  wire cpid_diag_type  diag_entry,     // location and type
   input  wire cpid_mgmt_type  slot1_out,      // mgmt output words 1..4
   input  wire logic [7:0]     slot2_out,      // output byte
   input  wire logic [7:0]     local_input_pin,// eight_input_group pins
   input  wire logic [15:0]    ext_status,     // extension master status
   input  wire logic           func_done,      // pulse: function finished
   output cpid_mgmt_type      slot1_in,       // mgmt input words 1..4
   output logic [7:0]         slot3_in,       // input byte
   output logic [3:0]         local_output,   // four_output_group drive
   output logic [15:0]        func_start,     // latched start word
   output logic [15:0]        func_param,     // latched param word
   output logic               link_fault_lamp,   // link fault lamp
   output logic               system_fault_lamp, // system fault lamp
   output cpid_alarm_type     alarm,          // alarm to controller
   output logic               named,          // station name held
   output logic               booted          // boot finished
);
   localparam int BLINK = `CPID_BLINK_CYCLES;
   localparam int BOOTC = `CPID_BOOT_CYCLES;
   localparam int UNITC = `CPID_DELAY_UNIT_CYC;

   cpid_state_type state;
   cpid_state_type next_state;
   logic [1:0]  btn_sync;
   logic [1:0]  btn_meta;
   logic        btn_prev;
   logic        btn_press;
   logic [7:0]  in_meta;
   logic [7:0]  in_sync;
   logic [15:0] prm;
   logic [31:0] timer;
   logic [7:0]  delay_units;
   logic [23:0] blink_cnt;
   logic        blink;
   logic        halt;
   logic        st_added;
   logic        st_removed;
   logic [3:0]  st_count;
   cpid_diag_type st_newest;
   logic        alarm_en;
   cpid_diag_type gone_entry;

   // pin synchronisers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         btn_meta <= 2'h3;
         btn_sync <= 2'h3;
         in_meta  <= 8'h00;
         in_sync  <= 8'h00;
         btn_prev <= 1'b1;
      end
      else
      begin
         btn_meta <= {btn_meta[0], reset_button_n};
         btn_sync <= {btn_sync[0], btn_meta[1]};
         in_meta  <= local_input_pin;
         in_sync  <= in_meta;
         btn_prev <= btn_sync[1];
      end
   end
   assign btn_press = btn_prev && !btn_sync[1];

   // startup parameters latched per connection
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prm <= `CPID_PRM_RESET;
      else if (conn_start)
         prm <= slot0_param;
   end

   // station name and address
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         named <= 1'b0;
      else if (name_assign)
         named <= 1'b1;
   end

   assign delay_units = prm[`CPID_PRM_DELAY_MSB:`CPID_PRM_DELAY_LSB];

   // boot / run / error stop sequencing
   always_comb
   begin
      next_state = state;
      unique case (state)
         CPID_BOOT:
            if (timer >= 32'(BOOTC - 1))
               next_state = CPID_RUN;
         CPID_RUN:
            if (bus_error || device_error)
               next_state = CPID_ERRSTOP;
         CPID_ERRSTOP:
            if (!bus_error && !device_error && prm[`CPID_PRM_AUTO_START])
               next_state = CPID_RESTART;
         CPID_RESTART:
            if (bus_error || device_error)
               next_state = CPID_ERRSTOP;
            else if (timer >= 32'(delay_units) * 32'(UNITC))
               next_state = CPID_RUN;
      endcase
      if (btn_press)
         next_state = CPID_BOOT;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= CPID_BOOT;
         timer <= '0;
      end
      else
      begin
         state <= next_state;
         timer <= (next_state != state) ? 32'h0000_0000 : timer + 32'h0000_0001;
      end
   end

   assign halt = (state != CPID_RUN) || bus_error || device_error;

   // local outputs and input image
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         local_output <= 4'h0;
         slot3_in     <= 8'h00;
         booted       <= 1'b0;
      end
      else
      begin
         booted <= (state != CPID_BOOT);
         if (halt || btn_press)
            local_output <= 4'h0;
         else
            local_output <= slot2_out[`CPID_OUT_USED_MSB:0];
         if (state != CPID_BOOT)
            slot3_in <= in_sync;
      end
   end

   // management slot
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot1_in   <= '0;
         func_start <= 16'h0000;
         func_param <= 16'h0000;
      end
      else
      begin
         if (halt || btn_press)
         begin
            func_start <= 16'h0000;
            func_param <= 16'h0000;
         end
         else
         begin
            func_start <= slot1_out.word1;
            func_param <= slot1_out.word2;
         end
         slot1_in.word1 <= {st_count != 4'h0, ext_status[14:0]};
         slot1_in.word2 <= {st_newest.location, st_newest.err_type};
         slot1_in.word3 <= {12'h000, st_count};
         slot1_in.word4 <= {14'h0000, state == CPID_ERRSTOP, func_start != 16'h0000 && !func_done};
      end
   end

   cpid_diag_store u_store (
      .clk     (clk),
      .rst_n   (rst_n),
      .clr     (btn_press),
      .add     (diag_add),
      .remove  (diag_remove),
      .entry   (diag_entry),
      .added   (st_added),
      .removed (st_removed),
      .count   (st_count),
      .newest  (st_newest)
   );

   // class enable and removed entry, aligned with the store pulses
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm_en   <= 1'b0;
         gone_entry <= '0;
      end
      else
      begin
         alarm_en <= diag_is_io ? prm[`CPID_PRM_EN_IODIAG] : prm[`CPID_PRM_EN_BUSDIAG];
         if (diag_remove)
            gone_entry <= diag_entry;
      end
   end

   // alarms to the controller
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         alarm <= '0;
      else
      begin
         alarm.valid    <= 1'b0;
         alarm.incoming <= 1'b0;
         if (st_added && alarm_en && conn_active)
         begin
            alarm.valid    <= 1'b1;
            alarm.incoming <= 1'b1;
            alarm.entry    <= st_newest;
         end
         else if (st_removed && alarm_en && conn_active)
         begin
            alarm.valid <= 1'b1;
            alarm.entry <= gone_entry;
         end
         else if (module_return && prm[`CPID_PRM_EN_RETURN] && conn_active)
         begin
            alarm.valid <= 1'b1;
            alarm.entry <= diag_entry;
         end
      end
   end

   // lamps
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blink_cnt         <= '0;
         blink             <= 1'b0;
         link_fault_lamp   <= 1'b1;
         system_fault_lamp <= 1'b0;
      end
      else
      begin
         if (blink_cnt >= 24'(BLINK - 1))
         begin
            blink_cnt <= '0;
            blink     <= !blink;
         end
         else
            blink_cnt <= blink_cnt + 24'h00_0001;
         if (state == CPID_BOOT || !link_up)
            link_fault_lamp <= 1'b1;
         else if (!conn_active)
            link_fault_lamp <= blink;
         else
            link_fault_lamp <= 1'b0;
         system_fault_lamp <= (st_count != 4'h0);
      end
   end

   // checks
   out_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_error || device_error) |=> local_output == 4'h0)
      else $error("outputs not zeroed on error");
   out_map_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state == CPID_RUN && !bus_error && !device_error && !btn_press) |=> local_output == $past(slot2_out[3:0]))
      else $error("output byte mapping wrong");
   in_map_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state != CPID_BOOT) |=> slot3_in == $past(in_sync))
      else $error("input byte mapping wrong");
   sys_lamp_a: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> system_fault_lamp == ($past(st_count) != 4'h0))
      else $error("system lamp mismatch");
   alarm_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      alarm.valid |-> $past(alarm_en || prm[`CPID_PRM_EN_RETURN]))
      else $error("alarm sent while disabled");
   alarm_in_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_added && alarm_en && conn_active) |=> alarm.valid && alarm.incoming)
      else $error("incoming alarm missing");
   alarm_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_removed && !st_added && alarm_en && conn_active) |=> alarm.valid && !alarm.incoming)
      else $error("outgoing alarm missing");
   link_lamp_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state != CPID_BOOT && link_up && conn_active) |=> !link_fault_lamp)
      else $error("link lamp lit while connected");
   prm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !conn_start |=> $stable(prm))
      else $error("parameters changed mid connection");
   btn_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      btn_press |=> local_output == 4'h0 ##1 state == CPID_BOOT)
      else $error("button did not clear outputs");
endmodule

// ### verilog/cpid_diag_store.sv
// diagnostic entry store: keeps location and type per occupied slot
// assumes add and remove requests from same clock domain
`include "cpid_defines.svh"
module cpid_diag_store
   import cpid_pkg::*;
(
   input  wire logic          clk,        // 40 MHz clock
   input  wire logic          rst_n,      // async reset, low
   input  wire logic          clr,        // drop all entries
   input  wire logic          add,        // store an entry
   input  wire logic          remove,     // remove matching entry
   input  wire cpid_diag_type entry,      // entry to add or remove
   output logic               added,      // pulse: entry stored
   output logic               removed,    // pulse: entry dropped
   output logic [3:0]         count,      // entries held
   output cpid_diag_type      newest      // last stored entry
);
   localparam int DEPTH = `CPID_DIAG_DEPTH;
   logic [DEPTH-1:0] used;
   cpid_diag_type    slot [DEPTH];
   logic [DEPTH-1:0] hit;
   logic [DEPTH-1:0] free_onehot;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : gen_hit
         assign hit[g] = used[g] && (slot[g] == entry);
      end
   endgenerate

   always_comb
   begin
      free_onehot = '0;
      for (int i = DEPTH - 1; i >= 0; i--)
         if (!used[i])
            free_onehot = DEPTH'(1) << i;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         used    <= '0;
         added   <= 1'b0;
         removed <= 1'b0;
         newest  <= '0;
      end
      else
      begin
         added   <= 1'b0;
         removed <= 1'b0;
         if (clr)
            used <= '0;
         else if (add && hit == '0 && free_onehot != '0)
         begin
            used   <= used | free_onehot;
            added  <= 1'b1;
            newest <= entry;
         end
         else if (remove && hit != '0)
         begin
            used    <= used & ~hit;
            removed <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < DEPTH; i++)
         if (add && !clr && hit == '0 && free_onehot[i])
            slot[i] <= entry;
   end

   always_comb
   begin
      count = '0;
      for (int i = 0; i < DEPTH; i++)
         count = count + 4'(used[i]);
   end
endmodule
